// ---- verilog/adcs_pkg.sv ----
`default_nettype none
package adcs_pkg;
   // ==========================================================
   // Command opcodes
   localparam logic [7:0] CMD_RESET     = 8'h06;
   localparam logic [7:0] CMD_START     = 8'h08;
   localparam logic [7:0] CMD_POWERDOWN = 8'h02;
   localparam logic [3:0] WRITE_CONFIG_CMD_NIB = 4'h4;
   localparam logic [3:0] READ_CONFIG_CMD_NIB  = 4'h2;

   // ==========================================================
   // Configuration layout
   localparam int         NUM_CFG      = 4;
   localparam logic [7:0] CFG_RESET    = 8'h00;
   localparam int         SEL_MSB      = 7;
   localparam int         SEL_LSB      = 4;
   localparam logic [3:0] SEL_SHORT    = 4'hE;
   localparam int         GAIN_MSB     = 3;
   localparam int         GAIN_LSB     = 1;
   localparam int         RATE_MSB     = 7;
   localparam int         RATE_LSB     = 5;
   localparam int         CONT_BIT     = 2;
   localparam int         TEMP_BIT     = 1;

   // ==========================================================
   // Data path
   localparam int         WORD_W       = 16;
   localparam int         FIFO_DEPTH   = 8;
   localparam logic [4:0] READ_EDGES   = 5'h10;
   localparam logic [2:0] LAST_BIT     = 3'h7;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS    = 10;
   localparam int RESET_WAIT_NS    = 50000;
   localparam int POWERUP_WAIT_NS  = 50000;
   localparam int RESET_EXTRA_CLKS = 32;
   localparam int RESET_WAIT_CYC   = (RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CLK_NS      = 244;

   // ==========================================================
   // Serial command states
   typedef enum logic [2:0] {
      ST_CMD   = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } adcs_ser_st_t;
endpackage
`default_nettype wire

// ---- verilog/adcs_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcs_fifo #(
   parameter int W = adcs_pkg::WORD_W,
   parameter int D = adcs_pkg::FIFO_DEPTH
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic         flush_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out
);
   import adcs_pkg::*;
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wr;
      logic [AW:0]         rd;
   } adcs_fifo_st_t;

   adcs_fifo_st_t q;
   adcs_fifo_st_t d;
   logic          full;
   logic          empty;

   // ==========================================================
   // Pointers carry one extra bit so full and empty differ.
   always_comb begin
      d = q;
      empty = (q.wr == q.rd);
      full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
      if (flush_in) begin
         d.wr = '0;
         d.rd = '0;
      end else begin
         if (in_valid_in && !full) begin
            d.mem[q.wr[AW-1:0]] = in_data_in;
            d.wr = q.wr + 1'b1;
         end
         if (out_ready_in && !empty) begin
            d.rd = q.rd + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Flush stays out of the handshake outputs so that they depend on state only
   // and cannot loop back through the caller's logic; the caller gates them.
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = q.mem[q.rd[AW-1:0]];
endmodule
`default_nettype wire

// ---- verilog/adcs_sequencer.sv ----
// Summary of operation
// - Serial link is mode 1: clock idles low, launch rising, sample falling.
// - Reset opcode restores defaults; host waits 50 us plus 32 converter clocks.
// - Write opcode followed by configuration bytes loads the configuration registers.
// - Read opcode shifts the configuration registers it selects back out, starting from its start register.
// - Start opcode begins conversions, repeating them in continuous mode.
// - Chip select high returns the serial logic to idle, dropping partial commands.
// - Active-low data ready falls when a new result is available.
// - Host reads a result with sixteen rising clock edges under chip select.
// - Power-down opcode stops conversions and enters the low-power state.
// - Input select code 1110 shorts both converter inputs to mid-supply.
// - Temperature sensor select bit set switches conversion to the on-chip sensor.
// - Writing 04h to register 01h selects 20 SPS, normal, continuous.
`timescale 1ns/1ps
`default_nettype none
module adcs_sequencer #(
   parameter int unsigned PWRUP_CYC = adcs_pkg::POWERUP_WAIT_CYC,
   parameter int unsigned RECOV_CYC = adcs_pkg::RESET_WAIT_CYC
                                    + adcs_pkg::RESET_EXTRA_CLKS
                                    * ((adcs_pkg::CONV_CLK_NS + adcs_pkg::CLK_PERIOD_NS - 1)
                                    / adcs_pkg::CLK_PERIOD_NS)
) (
   input  wire logic                      clk_in,
   input  wire logic                      rst_b_in,
   input  wire logic                      sclk_in,
   input  wire logic                      cs_n_in,
   input  wire logic                      din_in,
   output logic                           data_out_ready_pin_out,
   output logic                           data_out_ready_pin_oe_out,
   output logic                           data_ready_n_out,
   output logic                           conv_start_out,
   input  wire logic                      result_valid_in,
   input  wire logic [adcs_pkg::WORD_W-1:0] result_data_in,
   output logic                           result_ready_out,
   output logic [3:0]                     input_select_field_out,
   output logic [2:0]                     gain_field_out,
   output logic [2:0]                     sample_rate_field_out,
   output logic                           continuous_out,
   output logic                           temp_sensor_select_out,
   output logic                           inputs_shorted_out,
   output logic [7:0]                     filter_ctrl_out,
   output logic [7:0]                     current_ctrl_out,
   output logic                           powered_down_out,
   output logic                           converting_out,
   output logic                           recovering_out
);
   import adcs_pkg::*;

   typedef struct packed {
      logic [2:0]                sclk_s;
      logic [2:0]                csn_s;
      logic [2:0]                din_s;
      logic                      sclk_f;
      logic                      csn_f;
      adcs_ser_st_t              sst;
      logic [2:0]                bit_cnt;
      logic [6:0]                rx;
      logic [4:0]                rise_cnt;
      logic [31:0]               tx;
      logic                      dout;
      logic                      oe;
      logic [1:0]                ptr;
      logic [1:0]                remain;
      logic [NUM_CFG-1:0][7:0]   cfg;
      logic [WORD_W-1:0]         hold;
      logic                      have_word;
      logic                      word_loaded;
      logic                      data_ready_n_n;
      logic                      run;
      logic                      pd;
      logic                      busy;
      logic                      start_p;
      logic [15:0]               rec_cnt;
   } adcs_seq_st_t;

   adcs_seq_st_t      q;
   adcs_seq_st_t      d;
   logic              sclk_rise;
   logic              sclk_fall;
   logic              cs_rise;
   logic              cs_fall;
   logic              byte_done;
   logic [7:0]        rx_byte;
   logic [31:0]       cfg_word;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic              fifo_flush;
   logic [WORD_W-1:0] fifo_data;

   // A pin change counts only once the second and third stages agree.
   function automatic logic changed(input logic [2:0] s, input logic f);
      changed = (s[1] == s[2]) && (s[2] != f);
   endfunction

   // ==========================================================
   // Result buffer between converter and serial readout
   adcs_fifo #(
      .W (WORD_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .flush_in      (fifo_flush),
      .in_valid_in   (result_valid_in),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (result_data_in),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_data)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      d = q;
      d.sclk_s = {q.sclk_s[1:0], sclk_in};
      d.csn_s = {q.csn_s[1:0], cs_n_in};
      d.din_s = {q.din_s[1:0], din_in};
      sclk_rise = changed(q.sclk_s, q.sclk_f) && q.sclk_s[2];
      sclk_fall = changed(q.sclk_s, q.sclk_f) && !q.sclk_s[2];
      cs_rise = changed(q.csn_s, q.csn_f) && q.csn_s[2];
      cs_fall = changed(q.csn_s, q.csn_f) && !q.csn_s[2];
      if (changed(q.sclk_s, q.sclk_f)) begin
         d.sclk_f = q.sclk_s[2];
      end
      if (changed(q.csn_s, q.csn_f)) begin
         d.csn_f = q.csn_s[2];
      end
      rx_byte = {q.rx, q.din_s[2]};
      byte_done = sclk_fall && !q.csn_f && (q.bit_cnt == LAST_BIT);
      cfg_word = {q.cfg[0], q.cfg[1], q.cfg[2], q.cfg[3]};
      fifo_out_ready = !q.have_word;
      fifo_flush = byte_done && !cs_rise && (q.sst == ST_CMD) && (rx_byte == CMD_RESET);
      d.start_p = 1'b0;
      if (q.rec_cnt != 16'h0000) begin
         d.rec_cnt = q.rec_cnt - 16'h0001;
      end
      // Result accepted by the buffer ends the running conversion.
      if (result_valid_in && fifo_in_ready && !fifo_flush) begin
         d.busy = 1'b0;
      end
      // Starting waits for buffer room, so a slow reader stalls the converter.
      if (q.run && !q.busy && !q.start_p && (q.rec_cnt == 16'h0000)
          && fifo_in_ready && !fifo_flush) begin
         d.start_p = 1'b1;
         d.busy = 1'b1;
         d.run = q.cfg[1][CONT_BIT];
      end
      if (fifo_out_valid && !q.have_word && !fifo_flush) begin
         d.hold = fifo_data;
         d.have_word = 1'b1;
         d.data_ready_n_n = 1'b0;
      end
      if (cs_fall) begin
         d.bit_cnt = 3'h0;
         d.rise_cnt = 5'h00;
         d.word_loaded = q.have_word;
         d.tx = q.have_word ? {q.hold, 16'h0000} : 32'h0000_0000;
         d.oe = 1'b1;
      end else if (cs_rise) begin
         d.sst = ST_CMD;
         d.bit_cnt = 3'h0;
         d.rise_cnt = 5'h00;
         d.word_loaded = 1'b0;
         d.oe = 1'b0;
      end else if (!q.csn_f) begin
         if (sclk_rise) begin
            d.dout = q.tx[31];
            d.tx = {q.tx[30:0], 1'b0};
            if (q.rise_cnt != READ_EDGES) begin
               d.rise_cnt = q.rise_cnt + 5'h01;
            end
            if (q.word_loaded && (q.rise_cnt == READ_EDGES - 5'h01)) begin
               d.have_word = 1'b0;
               d.word_loaded = 1'b0;
               d.data_ready_n_n = 1'b1;
            end
         end
         if (sclk_fall) begin
            d.rx = rx_byte[6:0];
            d.bit_cnt = q.bit_cnt + 3'h1;
         end
         if (byte_done) begin
            unique case (q.sst)
               ST_CMD: begin
                  if (rx_byte == CMD_RESET) begin
                     for (int i = 0; i < NUM_CFG; i++) begin
                        d.cfg[i] = CFG_RESET;
                     end
                     d.run = 1'b0;
                     d.pd = 1'b0;
                     d.rec_cnt = 16'(RECOV_CYC);
                     d.have_word = 1'b0;
                     d.word_loaded = 1'b0;
                     d.data_ready_n_n = 1'b1;
                  end else if (rx_byte[7:4] == WRITE_CONFIG_CMD_NIB) begin
                     d.ptr = rx_byte[3:2];
                     d.remain = rx_byte[1:0];
                     d.sst = ST_WRITE;
                  end else if (rx_byte[7:4] == READ_CONFIG_CMD_NIB) begin
                     d.tx = cfg_word << {rx_byte[3:2], 3'b000};
                     d.remain = rx_byte[1:0];
                     d.sst = ST_READ;
                  end else if (rx_byte == CMD_START) begin
                     d.run = 1'b1;
                     d.pd = 1'b0;
                  end else if (rx_byte == CMD_POWERDOWN) begin
                     d.run = 1'b0;
                     d.pd = 1'b1;
                  end
               end
               ST_WRITE: begin
                  d.cfg[q.ptr] = rx_byte;
                  d.ptr = q.ptr + 2'h1;
                  d.remain = q.remain - 2'h1;
                  if (q.remain == 2'h0) begin
                     d.sst = ST_CMD;
                  end
               end
               ST_READ: begin
                  d.remain = q.remain - 2'h1;
                  if (q.remain == 2'h0) begin
                     d.sst = ST_CMD;
                  end
               end
            endcase
         end
      end
      // With chip select low and before the first clock rise, the shared pin mirrors data ready.
      if (!d.csn_f && (d.rise_cnt == 5'h00)) begin
         d.dout = d.data_ready_n_n;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
         q.csn_s <= 3'b111;
         q.csn_f <= 1'b1;
         q.sst <= ST_CMD;
         q.data_ready_n_n <= 1'b1;
         q.dout <= 1'b1;
         q.rec_cnt <= 16'(PWRUP_CYC);
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign data_out_ready_pin_out = q.dout;
   assign data_out_ready_pin_oe_out = q.oe;
   assign data_ready_n_out = q.data_ready_n_n;
   assign conv_start_out = q.start_p;
   assign result_ready_out = fifo_in_ready && !fifo_flush;
   assign input_select_field_out = q.cfg[0][SEL_MSB:SEL_LSB];
   assign gain_field_out = q.cfg[0][GAIN_MSB:GAIN_LSB];
   assign sample_rate_field_out = q.cfg[1][RATE_MSB:RATE_LSB];
   assign continuous_out = q.cfg[1][CONT_BIT];
   assign temp_sensor_select_out = q.cfg[1][TEMP_BIT];
   assign inputs_shorted_out = (q.cfg[0][SEL_MSB:SEL_LSB] == SEL_SHORT);
   assign filter_ctrl_out = q.cfg[2];
   assign current_ctrl_out = q.cfg[3];
   assign powered_down_out = q.pd;
   assign converting_out = q.busy;
   assign recovering_out = (q.rec_cnt != 16'h0000);

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_cmd(logic [7:0] op);
      byte_done && (q.sst == ST_CMD) && (rx_byte == op);
   endsequence

   sequence s_frame_end;
      cs_rise ##1 1'b1;
   endsequence

   a_float_idle: assert property (q.csn_f |-> !data_out_ready_pin_oe_out)
      else $error("data pin driven while deselected");
   a_cs_idle_state: assert property (s_frame_end |-> (q.sst == ST_CMD) && (q.bit_cnt == 3'h0))
      else $error("serial logic not idle after deselect");
   a_reset_cmd: assert property (s_cmd(CMD_RESET) |=> (q.cfg == '0) && recovering_out
                                 && data_ready_n_out [*2])
      else $error("reset command did not restore defaults");
   a_start_cmd: assert property (s_cmd(CMD_START) ##1 (q.rec_cnt == 16'h0000 && fifo_in_ready
                                 && !q.busy) |-> ##[0:1] conv_start_out)
      else $error("start command did not start a conversion");
   a_powerdown_cmd: assert property (s_cmd(CMD_POWERDOWN) |=> powered_down_out && !q.run
                                     ##1 !q.run)
      else $error("power-down command did not stop conversions");
   a_read_load: assert property (s_cmd(8'h23) |=> q.tx == $past(cfg_word))
      else $error("configuration read-back not loaded");
   a_write_cfg: assert property (byte_done && (q.sst == ST_WRITE) |=>
                                 q.cfg[$past(q.ptr)] == $past(rx_byte))
      else $error("configuration byte not stored");
   a_ready_word: assert property ($fell(data_ready_n_out) |-> q.have_word)
      else $error("data ready low without a result");
   a_msb_first: assert property (sclk_rise && !q.csn_f |=> data_out_ready_pin_out == $past(q.tx[31]))
      else $error("output bit not most significant first");
   a_sixteen_edges: assert property ($rose(data_ready_n_out) && !$past(fifo_flush)
                                     |-> $past(q.rise_cnt) == READ_EDGES - 5'h01)
      else $error("result consumed before sixteen edges");
   a_short_code: assert property (inputs_shorted_out == (input_select_field_out == 4'hE))
      else $error("input short decode wrong");
   a_rate_cfg: assert property (q.cfg[1] == 8'h04 |-> sample_rate_field_out == 3'h0
                                && continuous_out && !temp_sensor_select_out)
      else $error("register 01h decode wrong");
endmodule
`default_nettype wire

// ---- bench/adcs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host side of the serial link: a mode 1 master with chip select.
// The clock stands low between frames, and data in is inverted when
// the device is deselected, so stale bits cannot pass for good ones.
module adcs_host_model (
   output logic     sclk_out,
   output logic     cs_n_out,
   output logic     din_out,
   input  wire logic pin_in
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out  = 1'b0;
   end

   // ==========================================================
   // One framed transfer, most significant bit first.
   task automatic xfer(input logic [39:0] tx, input int nbits, output logic [39:0] rx);
      int i;
      rx = '0;
      cs_n_out = 1'b0;
      #100;
      for (i = 0; i < nbits; i++) begin
         din_out  = tx[nbits-1-i];
         sclk_out = 1'b1;
         #62.5;
         rx = {rx[38:0], pin_in};
         sclk_out = 1'b0;
         #62.5;
      end
      #100;
      cs_n_out = 1'b1;
      din_out  = ~din_out;
      #200;
   endtask
endmodule
`default_nettype wire

// ---- bench/adc_spi_command_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_spi_command_sequencer_bench;
   import adcs_pkg::*;
   // Short counts keep the run brief; recovery outlasts a frame's tail.
   localparam int PW = 20;
   localparam int RC = 80;

   logic              clk_in          = 1'b0;
   logic              rst_b_in        = 1'b0;
   logic              result_valid_in = 1'b0;
   logic [WORD_W-1:0] result_data_in  = '0;
   logic              tog_q           = 1'b0;
   wire logic         sclk_w, cs_n_w, din_w, pin_w;
   wire logic         pin_o, pin_oe, data_ready_n_n, conv_start, res_ready;
   wire logic [3:0]   sel;
   wire logic [2:0]   gain, rate;
   wire logic         cont, temp, shorted, pdown, conv, recov;
   wire logic [7:0]   filt, curr;
   int                errors = 0;
   int                n_checks = 0;
   int                n_starts = 0;
   int                cycles = 0;
   logic [15:0]       exp_q[$];

   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) tog_q <= ~tog_q;
   assign pin_w = pin_oe ? pin_o : tog_q;

   adcs_sequencer #(.PWRUP_CYC(PW), .RECOV_CYC(RC)) u_dut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk_w), .cs_n_in(cs_n_w),
      .din_in(din_w), .data_out_ready_pin_out(pin_o), .data_out_ready_pin_oe_out(pin_oe),
      .data_ready_n_out(data_ready_n_n), .conv_start_out(conv_start),
      .result_valid_in(result_valid_in), .result_data_in(result_data_in),
      .result_ready_out(res_ready), .input_select_field_out(sel), .gain_field_out(gain),
      .sample_rate_field_out(rate), .continuous_out(cont), .temp_sensor_select_out(temp),
      .inputs_shorted_out(shorted), .filter_ctrl_out(filt), .current_ctrl_out(curr),
      .powered_down_out(pdown), .converting_out(conv), .recovering_out(recov));

   adcs_host_model u_host (.sclk_out(sclk_w), .cs_n_out(cs_n_w), .din_out(din_w), .pin_in(pin_w));

   // ==========================================================
   // Converter model: one result per start, held until accepted.
   always begin
      @(posedge clk_in);
      if (conv_start === 1'b1) begin
         n_starts++;
         repeat (2 + $urandom % 8) @(posedge clk_in);
         #1;
         result_valid_in = 1'b1;
         result_data_in  = 16'($urandom);
         do @(posedge clk_in); while (res_ready !== 1'b1);
         exp_q.push_back(result_data_in);
         #1;
         result_valid_in = 1'b0;
      end
   end

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hang costs a mismatch and ends the run at the same report.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         stop_test();
      end
   end

   initial begin
      logic [39:0] rx;
      logic [7:0]  v0, v1;
      int          k, s, n_rd, sum_seen, sum_exp;
      logic [15:0] exp_w;
      void'($urandom(40306));
      repeat (4) @(posedge clk_in);
      #1 rst_b_in = 1'b1;
      check("recovering", 40'(recov), 40'h1);
      check("ready_n", 40'(data_ready_n_n), 40'h1);
      check("oe", 40'(pin_oe), 40'h0);
      check("gain", 40'(gain), 40'h0);
      repeat (PW + 5) @(posedge clk_in);
      #1;
      check("recovering", 40'(recov), 40'h0);
      u_host.xfer(40'h06, 8, rx);
      check("recovering", 40'(recov), 40'h1);
      for (k = 0; k < 200 && recov !== 1'b0; k++) @(posedge clk_in);
      #1;
      check("recovering", 40'(recov), 40'h0);
      u_host.xfer(40'h43_0804_1000, 40, rx);
      check("cfg", 40'({sel, gain, rate, cont, temp, filt, curr}),
            40'({4'h0, 3'h4, 3'h0, 1'b1, 1'b0, 8'h10, 8'h00}));
      u_host.xfer(40'h23_0000_0000, 40, rx);
      check("readback", 40'(rx[31:0]), 40'h08_0410_00);
      for (int i = 0; i < 4; i++) begin
         v0 = 8'($urandom);
         v1 = 8'($urandom);
         if (i == 0) v0[7:4] = SEL_SHORT;
         if (i == 1) v1[TEMP_BIT] = 1'b1;
         u_host.xfer(40'({8'h41, v0, v1}), 24, rx);
         check("sel", 40'(sel), 40'(v0[7:4]));
         check("short", 40'(shorted), 40'(v0[7:4] == SEL_SHORT));
         check("gain", 40'(gain), 40'(v0[3:1]));
         check("rate", 40'({rate, cont}), 40'({v1[7:5], v1[2]}));
         check("temp", 40'(temp), 40'(v1[1]));
      end
      u_host.xfer(40'h44_04, 16, rx);
      check("reg1", 40'({rate, cont, temp}), 40'({3'h0, 1'b1, 1'b0}));
      // A partial byte cut off by chip select must not spoil the next opcode.
      u_host.xfer(40'h00, 6, rx);
      check("oe", 40'(pin_oe), 40'h0);
      u_host.xfer(40'h08, 8, rx);
      for (k = 0; k < 300 && n_starts == 0; k++) @(posedge clk_in);
      #1;
      check("started", 40'(n_starts > 0), 40'h1);
      for (k = 0; k < 3000 && res_ready !== 1'b0; k++) @(posedge clk_in);
      #1;
      check("full", 40'(res_ready), 40'h0);
      check("busy", 40'(conv), 40'h0);
      check("ready_n", 40'(data_ready_n_n), 40'h0);
      check("depth", 40'(exp_q.size() >= FIFO_DEPTH), 40'h1);
      u_host.xfer(40'h02, 8, rx);
      check("pdown", 40'(pdown), 40'h1);
      sum_seen = 0;
      sum_exp = 0;
      n_rd = 0;
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
         for (k = 0; k < 100 && data_ready_n_n !== 1'b0; k++) @(posedge clk_in);
         #1;
         check("ready_n", 40'(data_ready_n_n), 40'h0);
         u_host.xfer(40'h0, 16, rx);
         exp_w = exp_q.pop_front();
         check("word", 40'(rx[15:0]), 40'(exp_w));
         sum_seen += $signed(rx[15:0]);
         sum_exp += $signed(exp_w);
         n_rd++;
         repeat (20) @(posedge clk_in);
         #1;
      end
      check("left", 40'(exp_q.size()), 40'h0);
      check("offset", 40'(sum_seen / n_rd), 40'(sum_exp / n_rd));
      check("ready_n", 40'(data_ready_n_n), 40'h1);
      s = n_starts;
      repeat (200) @(posedge clk_in);
      #1;
      check("starts", 40'(n_starts), 40'(s));
      u_host.xfer(40'h06, 8, rx);
      check("cfg", 40'({sel, gain, rate, cont, temp, filt, curr}), 40'h0);
      // Defaults leave single conversion mode: one start gives exactly one result.
      s = n_starts;
      u_host.xfer(40'h08, 8, rx);
      repeat (300) @(posedge clk_in);
      #1;
      check("single", 40'(n_starts), 40'(s + 1));
      check("ready_n", 40'(data_ready_n_n), 40'h0);
      u_host.xfer(40'h0, 16, rx);
      check("word", 40'(rx[15:0]), 40'(exp_q.pop_front()));
      stop_test();
   end
endmodule
`default_nettype wire
